// [hw/fsg_pkg.sv]
// Package with constants and carriers for the flash security level guard
// Operation
// - Software byte FFh means level 0; level 1 or 2 may be written.
// - Software byte program command accepted only when it raises the level.
// - Level 1 FEh refuses code, boot status and vector writes; answer 'P'.
// - At level 1 only a write setting level 2 is accepted.
// - Level 2 FCh blocks all code and data reads and writes; answer 'L'.
// - Only full chip erase returns the software byte to unprotected.
// - Level bits sit in bits 1-0; upper six bits reserved, kept set.
// - Lock bits read 1 unprogrammed, 0 programmed; all unprogrammed means no locking.
// - Hardware level 2 blocks external code reads, latches access pin, stops parallel programming.
// - Hardware level 3 also refuses parallel code verification.
// - Hardware level 4, the default, also disables external execution.
// - Default hardware byte: loader jump programmed, speed double and data memory unprogrammed.
package fsg_pkg;
   localparam logic [7:0] SOFT_LVL0 = 8'hff;
   localparam logic [7:0] SOFT_LVL1 = 8'hfe;
   localparam logic [7:0] SOFT_LVL2 = 8'hfc;
   localparam logic [7:0] SOFT_RSV_MASK = 8'hfc;
   localparam int SOFT_LVL_LSB = 0;
   // Hardware byte field positions
   localparam int HW_JUMP_POS = 7;
   localparam int HW_SPEED_POS = 6;
   localparam int HW_MEMOPT_POS = 3;
   localparam int HW_LOCK0_POS = 0;
   localparam int HW_LOCK1_POS = 1;
   localparam int HW_LOCK2_POS = 2;
   // Jump programmed, speed and memory unprogrammed, level 4
   localparam logic [7:0] HW_DEFAULT = 8'h78;
   localparam logic [7:0] CHAR_P = 8'h50;
   localparam logic [7:0] CHAR_L = 8'h4c;
   localparam logic [7:0] CHAR_OK = 8'h00;

   typedef enum logic [2:0] {
      FSG_OP_READ,
      FSG_OP_WRITE,
      FSG_OP_VERIFY,
      FSG_OP_ERASE_BLOCK,
      FSG_OP_CHIP_ERASE,
      FSG_OP_PROG_SOFT
   } fsg_op_t;

   typedef enum logic [1:0] {
      FSG_SRC_ISP,
      FSG_SRC_API,
      FSG_SRC_PAR
   } fsg_src_t;

   typedef enum logic [2:0] {
      FSG_TGT_CODE,
      FSG_TGT_DATA,
      FSG_TGT_BOOT_STATUS,
      FSG_TGT_BOOT_VECTOR,
      FSG_TGT_SOFT_BYTE,
      FSG_TGT_INFO
   } fsg_tgt_t;

   typedef struct packed {
      fsg_op_t op;
      fsg_src_t src;
      fsg_tgt_t tgt;
      logic [7:0] wdata;
   } fsg_req_t;

   typedef struct packed {
      logic grant;
      logic refuse;
      logic [7:0] reply;
   } fsg_rsp_t;
endpackage

// [hw/fsg_guard.sv]
// Flash security level guard: protection byte store and access gating
`timescale 1ns/100ps
module fsg_guard (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] nv_soft_byte,
   input wire logic [7:0] nv_hw_byte,
   input wire logic ext_access_pin,
   input wire logic req_valid,
   input wire fsg_pkg::fsg_req_t req,
   input wire logic ext_code_read,
   input wire logic ext_fetch,
   output fsg_pkg::fsg_rsp_t rsp,
   output logic rsp_valid,
   output logic [7:0] software_protection_byte,
   output logic [7:0] hardware_protection_byte,
   output logic [1:0] soft_level,
   output logic [2:0] hw_level,
   output logic ext_access_latched,
   output logic code_read_block,
   output logic ext_exec_block,
   output logic loader_jump_bit,
   output logic speed_double_bit,
   output logic internal_data_memory_option,
   output logic soft_nv_we,
   output logic [7:0] soft_nv_wdata
);
   // ------------------------------------------------------------
   // Storage and pin sampling
   // ------------------------------------------------------------
   logic [7:0] soft_ff;
   logic [7:0] hw_ff;
   logic loaded_ff;
   logic [2:0] pin_sync_ff;
   logic pin_stable_ff;
   logic ext_access_ff;
   fsg_pkg::fsg_rsp_t rsp_ff;
   logic rsp_valid_ff;
   logic nv_we_ff;
   logic [7:0] nv_wdata_ff;

   // ------------------------------------------------------------
   // Level decode
   // ------------------------------------------------------------
   wire [1:0] soft_level_bits = soft_ff[1:0];
   wire lvl_s0 = (soft_level_bits == 2'b11);
   wire lvl_s1 = (soft_level_bits == 2'b10);
   // Bit 1 clear is level 2; the unused code 01 falls on the safe side
   wire lvl_s2 = ~soft_level_bits[1];
   // Lock bits in the low three positions of the hardware byte
   wire lock_bit_zero = hw_ff[fsg_pkg::HW_LOCK0_POS];
   wire lock_bit_one = hw_ff[fsg_pkg::HW_LOCK1_POS];
   wire lock_bit_two = hw_ff[fsg_pkg::HW_LOCK2_POS];
   // Programmed lock bit reads 0; highest programmed bit wins
   wire [2:0] hw_lvl = ~lock_bit_two ? 3'd4 : ~lock_bit_one ? 3'd3 : ~lock_bit_zero ? 3'd2 : 3'd1;
   wire hw_ge2 = (hw_lvl >= 3'd2);
   wire hw_ge3 = (hw_lvl >= 3'd3);
   wire hw_ge4 = (hw_lvl == 3'd4);

   // ------------------------------------------------------------
   // Request decision
   // ------------------------------------------------------------
   wire is_rd = (req.op == fsg_pkg::FSG_OP_READ);
   wire is_wr = (req.op == fsg_pkg::FSG_OP_WRITE) || (req.op == fsg_pkg::FSG_OP_ERASE_BLOCK);
   wire is_ver = (req.op == fsg_pkg::FSG_OP_VERIFY);
   wire is_chip = (req.op == fsg_pkg::FSG_OP_CHIP_ERASE);
   wire is_prog = (req.op == fsg_pkg::FSG_OP_PROG_SOFT);
   wire from_par = (req.src == fsg_pkg::FSG_SRC_PAR);
   wire tgt_mem = (req.tgt == fsg_pkg::FSG_TGT_CODE) || (req.tgt == fsg_pkg::FSG_TGT_DATA);
   wire tgt_boot = (req.tgt == fsg_pkg::FSG_TGT_BOOT_STATUS) || (req.tgt == fsg_pkg::FSG_TGT_BOOT_VECTOR);
   wire tgt_info = (req.tgt == fsg_pkg::FSG_TGT_INFO);
   // Reserved bits forced set so a careless write cannot clear them
   wire [7:0] new_soft = req.wdata | fsg_pkg::SOFT_RSV_MASK;
   // A cleared bit means higher level; must program a strict superset
   wire raises = ((new_soft[1:0] & soft_level_bits) == new_soft[1:0]) && (new_soft[1:0] != soft_level_bits)
                 && (new_soft[1:0] != 2'b01);
   wire par_deny = from_par && !is_chip && (hw_ge2 && (is_wr || is_prog)
                   || hw_ge3 && is_ver);
   wire s2_deny = lvl_s2 && !is_chip && !is_prog && !(is_rd && tgt_info)
                  && (tgt_mem || tgt_boot || is_wr);
   wire s1_deny = lvl_s1 && is_wr && (tgt_mem || tgt_boot);
   wire prog_deny = is_prog && !raises;
   wire info_wr_deny = is_wr && tgt_info;
   wire deny = par_deny || s2_deny || s1_deny || prog_deny || info_wr_deny;
   wire [7:0] deny_char = lvl_s2 ? fsg_pkg::CHAR_L : fsg_pkg::CHAR_P;
   wire do_prog = req_valid && is_prog && !deny;
   wire do_chip = req_valid && is_chip;

   wire [7:0] nxt_soft = do_chip ? fsg_pkg::SOFT_LVL0 : do_prog ? new_soft : soft_ff;
   wire [7:0] nxt_hw = do_chip ? fsg_pkg::HW_DEFAULT : hw_ff;

   // ------------------------------------------------------------
   // Load and pin next values
   // ------------------------------------------------------------
   // Reserved bits forced set on load too, whatever the store holds
   wire [7:0] nxt_soft_load = nv_soft_byte | fsg_pkg::SOFT_RSV_MASK;
   wire [7:0] nxt_soft_sel = loaded_ff ? nxt_soft : nxt_soft_load;
   wire [7:0] nxt_hw_sel = loaded_ff ? nxt_hw : nv_hw_byte;
   wire [2:0] nxt_pin_sync = {pin_sync_ff[1:0], ext_access_pin};
   // Late stages must agree, so one unsettled sample is ignored
   wire pin_agree = (pin_sync_ff[1] == pin_sync_ff[2]);
   wire nxt_pin_stable = pin_agree ? pin_sync_ff[2] : pin_stable_ff;
   // Frozen from load when locked, so a later pin change cannot reopen access
   wire nxt_ext_access = (!loaded_ff || !hw_ge2) ? pin_stable_ff : ext_access_ff;

   // ------------------------------------------------------------
   // Response next values
   // ------------------------------------------------------------
   // No answer in the load cycle: levels not yet known
   wire take = req_valid && loaded_ff;
   wire nxt_grant = take && !deny;
   wire nxt_refuse = take && deny;
   wire [7:0] nxt_reply = nxt_refuse ? deny_char : fsg_pkg::CHAR_OK;
   wire fsg_pkg::fsg_rsp_t nxt_rsp = {nxt_grant, nxt_refuse, nxt_reply};
   wire nxt_nv_we = loaded_ff && (do_prog || do_chip);

   // ------------------------------------------------------------
   // Software byte
   // ------------------------------------------------------------
   // Safe level 2 until the store is read
   always_ff @(posedge clk) begin
      if (srst) begin
         soft_ff <= fsg_pkg::SOFT_LVL2;
      end else begin
         soft_ff <= nxt_soft_sel;
      end
   end

   // ------------------------------------------------------------
   // Hardware byte
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         hw_ff <= fsg_pkg::HW_DEFAULT;
      end else begin
         hw_ff <= nxt_hw_sel;
      end
   end

   // ------------------------------------------------------------
   // Load flag
   // ------------------------------------------------------------
   // One load per reset; bytes then change only on erase or a software byte program until reset
   always_ff @(posedge clk) begin
      if (srst) begin
         loaded_ff <= 1'b0;
      end else begin
         loaded_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------
   // No reset on the pin stages, so the pin has settled when reset lifts
   always_ff @(posedge clk) begin
      pin_sync_ff <= nxt_pin_sync;
      pin_stable_ff <= nxt_pin_stable;
   end

   // ------------------------------------------------------------
   // External access latch
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ext_access_ff <= 1'b0;
      end else begin
         ext_access_ff <= nxt_ext_access;
      end
   end

   // ------------------------------------------------------------
   // Response
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         rsp_ff <= '0;
         rsp_valid_ff <= 1'b0;
      end else begin
         rsp_ff <= nxt_rsp;
         rsp_valid_ff <= take;
      end
   end

   // ------------------------------------------------------------
   // Store write
   // ------------------------------------------------------------
   // Written value is the next byte, so store and register agree
   always_ff @(posedge clk) begin
      if (srst) begin
         nv_we_ff <= 1'b0;
         nv_wdata_ff <= 8'h00;
      end else begin
         nv_we_ff <= nxt_nv_we;
         nv_wdata_ff <= nxt_soft;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Decoded from registers, stable between commands
   assign rsp = rsp_ff;
   assign rsp_valid = rsp_valid_ff;
   assign software_protection_byte = soft_ff;
   assign hardware_protection_byte = hw_ff;
   assign soft_level = lvl_s0 ? 2'd0 : lvl_s1 ? 2'd1 : 2'd2;
   assign hw_level = hw_lvl;
   assign ext_access_latched = ext_access_ff;
   assign loader_jump_bit = hw_ff[fsg_pkg::HW_JUMP_POS];
   assign speed_double_bit = hw_ff[fsg_pkg::HW_SPEED_POS];
   assign internal_data_memory_option = hw_ff[fsg_pkg::HW_MEMOPT_POS];
   assign soft_nv_we = nv_we_ff;
   assign soft_nv_wdata = nv_wdata_ff;

   // ------------------------------------------------------------
   // Access gates
   // ------------------------------------------------------------
   // Combinational so a blocked access is stopped in its own cycle
   assign code_read_block = hw_ge2 && ext_code_read;
   assign ext_exec_block = hw_ge4 && ext_fetch;
endmodule

// [sim/fsg_nv_model.sv]
// Nonvolatile byte store that feeds the guard on reset exit
`timescale 1ns/100ps
module fsg_nv_model (
   input wire logic clk,
   input wire logic soft_nv_we,
   input wire logic [7:0] soft_nv_wdata,
   input wire logic [7:0] hw_init,
   output logic [7:0] nv_soft_byte,
   output logic [7:0] nv_hw_byte
);
   logic [7:0] soft_ff = 8'hff;
   always @(posedge clk) begin
      if (soft_nv_we) begin
         soft_ff <= soft_nv_wdata;
      end
   end
   assign nv_soft_byte = soft_ff;
   // Hardware byte set by the programmer side
   assign nv_hw_byte = hw_init;
endmodule

// [sim/fsg_guard_checker.sv]
// Assertions on the security guard ports
`timescale 1ns/100ps
module fsg_guard_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire fsg_pkg::fsg_req_t req,
   input wire logic ext_fetch,
   input wire fsg_pkg::fsg_rsp_t rsp,
   input wire logic rsp_valid,
   input wire logic [7:0] software_protection_byte,
   input wire logic [7:0] hardware_protection_byte,
   input wire logic [1:0] soft_level,
   input wire logic [2:0] hw_level,
   input wire logic ext_exec_block
);
   logic [1:0] up_ff;
   // Skip the load cycle: pre-load levels are not real
   always_ff @(posedge clk) begin
      up_ff <= srst ? 2'b00 : {up_ff[0], 1'b1};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_take;
      req_valid && up_ff[0];
   endsequence
   a_answer_next: assert property (s_take |=> rsp_valid) else $error("no answer after request");
   a_reserved_set: assert property (software_protection_byte[7:2] == 6'h3f) else $error("reserved bits clear");
   a_soft_decode: assert property (soft_level == (software_protection_byte[1] ?
      (software_protection_byte[0] ? 2'd0 : 2'd1) : 2'd2)) else $error("soft level decode wrong");
   a_never_lower: assert property (up_ff[1] && soft_level < $past(soft_level)
      |-> $past(req_valid && req.op == fsg_pkg::FSG_OP_CHIP_ERASE)) else $error("level lowered");
   a_erase_clears: assert property (s_take ##0 req.op == fsg_pkg::FSG_OP_CHIP_ERASE
      |=> software_protection_byte == 8'hff && rsp.grant) else $error("erase did not clear");
   a_lvl2_blocks: assert property (s_take ##0 soft_level == 2'd2 && req.tgt == fsg_pkg::FSG_TGT_CODE
      && (req.op == fsg_pkg::FSG_OP_READ || req.op == fsg_pkg::FSG_OP_WRITE)
      && req.src == fsg_pkg::FSG_SRC_ISP |=> rsp.refuse && rsp.reply == 8'h4c) else $error("level 2 leak");
   a_hw_decode: assert property (hw_level == (!hardware_protection_byte[2] ? 3'd4 :
      !hardware_protection_byte[1] ? 3'd3 : !hardware_protection_byte[0] ? 3'd2 : 3'd1)) else $error("hw decode");
   a_par_locked: assert property (s_take ##0 req.src == fsg_pkg::FSG_SRC_PAR && hw_level >= 3'd2
      && req.op == fsg_pkg::FSG_OP_WRITE |=> rsp.refuse) else $error("parallel write allowed");
   a_exec_block: assert property (ext_exec_block == (hw_level == 3'd4 && ext_fetch)) else $error("exec gate");
endmodule
bind fsg_guard fsg_guard_checker u_chk (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
   .ext_fetch(ext_fetch), .rsp(rsp), .rsp_valid(rsp_valid), .software_protection_byte(software_protection_byte),
   .hardware_protection_byte(hardware_protection_byte), .soft_level(soft_level), .hw_level(hw_level),
   .ext_exec_block(ext_exec_block));

// [sim/fsg_guard_tb.sv]
// Self-checking bench for the flash security level guard
`timescale 1ns/100ps
module fsg_guard_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0;
   fsg_pkg::fsg_req_t req = '0;
   logic ext_code_read = 1'b0;
   logic ext_fetch = 1'b0;
   logic [7:0] hw_init = 8'h78;
   logic ext_pin = 1'b1;
   logic [7:0] nv_soft_byte, nv_hw_byte, soft_nv_wdata, soft_byte, hw_byte;
   logic soft_nv_we, rsp_valid, crb, xeb, jump_bit, speed_bit, mem_bit, ext_latched;
   logic [1:0] soft_level;
   logic [2:0] hw_level;
   fsg_pkg::fsg_rsp_t rsp;
   int bad_count = 0;
   int comparisons = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   fsg_nv_model u_nv (.clk(clk), .soft_nv_we(soft_nv_we), .soft_nv_wdata(soft_nv_wdata), .hw_init(hw_init),
      .nv_soft_byte(nv_soft_byte), .nv_hw_byte(nv_hw_byte));
   fsg_guard dut (.clk(clk), .srst(srst), .nv_soft_byte(nv_soft_byte), .nv_hw_byte(nv_hw_byte),
      .ext_access_pin(ext_pin), .req_valid(req_valid), .req(req), .ext_code_read(ext_code_read),
      .ext_fetch(ext_fetch), .rsp(rsp), .rsp_valid(rsp_valid), .software_protection_byte(soft_byte),
      .hardware_protection_byte(hw_byte), .soft_level(soft_level), .hw_level(hw_level),
      .ext_access_latched(ext_latched), .code_read_block(crb),
      .ext_exec_block(xeb), .loader_jump_bit(jump_bit), .speed_double_bit(speed_bit),
      .internal_data_memory_option(mem_bit), .soft_nv_we(soft_nv_we), .soft_nv_wdata(soft_nv_wdata));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Op, source, target, data; exp ff means refused with any reply
   task automatic send(input logic [2:0] op, input logic [1:0] src, input logic [2:0] tgt, input logic [7:0] wd,
      input logic [7:0] exp);
      @(negedge clk);
      req_valid = 1'b1;
      req = {op, src, tgt, wd};
      @(negedge clk);
      req_valid = 1'b0;
      chk({7'h00, rsp_valid}, 8'h01);
      chk({6'h00, rsp.grant, rsp.refuse}, (exp == 8'h00) ? 8'h02 : 8'h01);
      if (exp != 8'hff) begin
         chk(rsp.reply, exp);
      end
   endtask
   task automatic do_reset(input logic [7:0] hw);
      @(negedge clk);
      srst = 1'b1;
      hw_init = hw;
      ext_pin = 1'b1;
      repeat (16) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic t_soft;
      chk({soft_level, jump_bit, speed_bit, mem_bit, hw_level}, 8'h1c);
      send(3'h5, 2'h0, 3'h4, 8'hfe, 8'h00);
      send(3'h5, 2'h0, 3'h4, 8'hff, 8'hff);
      do_reset(8'h78);
      chk({6'h00, soft_level}, 8'h01);
      send(3'h0, 2'h0, 3'h0, 8'h00, 8'h00);
      for (int t = 0; t < 4; t++) begin
         send(3'h1, 2'h0, t[2:0], 8'h00, (t == 1) ? 8'hff : 8'h50);
      end
      send(3'h3, 2'h1, 3'h0, 8'h00, 8'h50);
      send(3'h5, 2'h0, 3'h4, 8'hfc, 8'h00);
      send(3'h0, 2'h0, 3'h0, 8'h00, 8'h4c);
      send(3'h1, 2'h0, 3'h1, 8'h00, 8'h4c);
      send(3'h0, 2'h1, 3'h5, 8'h00, 8'h00);
      send(3'h5, 2'h0, 3'h4, 8'hfe, 8'hff);
      send(3'h4, 2'h2, 3'h0, 8'h00, 8'h00);
      chk(soft_byte, 8'hff);
      send(3'h1, 2'h0, 3'h2, 8'h00, 8'h00);
      send(3'h5, 2'h0, 3'h4, 8'hfc, 8'h00);
      send(3'h4, 2'h0, 3'h0, 8'h00, 8'h00);
      chk(soft_byte, 8'hff);
      $display("soft level test done");
   endtask
   task automatic t_hw;
      logic [7:0] hb [4] = '{8'hff, 8'hfe, 8'hfc, 8'hf8};
      for (int i = 0; i < 4; i++) begin
         do_reset(hb[i]);
         chk({5'h00, hw_level}, i[7:0] + 8'h01);
         chk(hw_byte, hb[i]);
         chk({7'h00, ext_latched}, 8'h01);
         send(3'h1, 2'h2, 3'h0, 8'h00, (i > 0) ? 8'hff : 8'h00);
         send(3'h2, 2'h2, 3'h0, 8'h00, (i > 1) ? 8'hff : 8'h00);
         ext_fetch = 1'b1;
         ext_code_read = 1'b1;
         ext_pin = 1'b0;
         @(negedge clk);
         chk({6'h00, crb, xeb}, {6'h00, i > 0, i == 3});
         ext_fetch = 1'b0;
         ext_code_read = 1'b0;
         repeat (6) @(negedge clk);
         chk({7'h00, ext_latched}, {7'h00, i > 0});
      end
      $display("hardware level test done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      t_soft();
      t_hw();
      wrap_up();
   end
   initial begin
      #20000;
      bad_count++;
      wrap_up();
   end
endmodule
